/* inc/asr_pkg.sv */
// package for the static memory host controller: timing, pin carriers.
// assumes a 100 MHz mclk and a one-bit-wide asynchronous memory outside.
// ---------------------------------------------------------------------
// Behaviour
// - address stable around whole write strobe
// - input data captured at write strobe rise
// - hold input data after select rise
// - wait 2 ms after power before access
// ---------------------------------------------------------------------
package asr_pkg;
    localparam int ADDR_W = 14;
    localparam int WORDS = 16384;
    localparam int CLK_PERIOD_NS = 10;
    // grade access times, ns (cycle time equals access time)
    localparam int ACCESS_NS = 70;
    localparam int STROBE_ADDRESS_SETUP_NS = 10;
    localparam int WRITE_PULSE_NS = 40;
    localparam int WRITE_DATA_HOLD_NS = 10;
    localparam int WRITE_RECOVERY_NS = 0;
    localparam int POWER_DOWN_DELAY_NS = 50;
    localparam int STARTUP_WAIT_MS = 2;
    // least times round up to whole cycles; a zero time gives zero cycles
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (STROBE_ADDRESS_SETUP_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (WRITE_DATA_HOLD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int STARTUP_CYC = STARTUP_WAIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    typedef struct packed {
        logic [ADDR_W-1:0] word_address;
        logic data_in;
        logic select_n;
        logic write_n;
    } asr_pins_t;

    typedef enum logic [5:0] {
        ST_WAKE = 6'h01,
        ST_IDLE = 6'h02,
        ST_READ = 6'h04,
        ST_WSET = 6'h08,
        ST_WPULSE = 6'h10,
        ST_WHOLD = 6'h20
    } asr_state_t;
endpackage

/* logic/asr_host.sv */
// host controller for a one-bit asynchronous static memory.
// assumes req is from mclk logic; mem_data_out is a pin, synchronised here.
`timescale 1ns/1ps
module asr_host #(
    parameter int STARTUP_CYCLES = asr_pkg::STARTUP_CYC,
    parameter int ACCESS_CYCLES = asr_pkg::ACCESS_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_data,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_data,
    output asr_pkg::asr_pins_t mem_pins,
    input wire logic mem_data_out
);
    import asr_pkg::*;

    asr_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    asr_pins_t pins_ff;
    logic dout_s1_ff, dout_s2_ff;
    logic ready_ff, rsp_valid_ff, rsp_data_ff;
    logic cnt_done;

    // ---------------------------------------------------------------
    // pin synchroniser
    // ---------------------------------------------------------------
    // two extra cycles of latency on top of the access time
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dout_s1_ff <= 1'b0;
            dout_s2_ff <= 1'b0;
        end else begin
            dout_s1_ff <= mem_data_out;
            dout_s2_ff <= dout_s1_ff;
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    assign cnt_done = (cnt_ff == '0);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        case (state_ff)
            ST_WAKE: begin
                if (cnt_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req_valid && req_write) begin
                    nxt_state = ST_WSET;
                    nxt_cnt = CNT_W'(SETUP_CYC - 1);
                end else if (req_valid) begin
                    nxt_state = ST_READ;
                    // +2: the first sync flop samples one cycle past the
                    // access time, never on the edge where data settles
                    nxt_cnt = CNT_W'(ACCESS_CYCLES + 2);
                end
            end
            ST_READ: begin
                if (cnt_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_WSET: begin
                if (cnt_done) begin
                    nxt_state = ST_WPULSE;
                    nxt_cnt = CNT_W'(PULSE_CYC - 1);
                end
            end
            ST_WPULSE: begin
                if (cnt_done) begin
                    nxt_state = ST_WHOLD;
                    nxt_cnt = CNT_W'(HOLD_CYC - 1);
                end
            end
            ST_WHOLD: begin
                if (cnt_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_ff <= ST_WAKE;
            cnt_ff <= CNT_W'(STARTUP_CYCLES - 1);
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ---------------------------------------------------------------
    // memory pins
    // ---------------------------------------------------------------
    // address and data latched only when leaving idle, so they stay
    // still through the whole strobe and its hold
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pins_ff <= '{word_address: '0, data_in: 1'b0,
                         select_n: 1'b1, write_n: 1'b1};
        end else begin
            if (state_ff == ST_IDLE && req_valid) begin
                pins_ff.word_address <= req_addr;
                pins_ff.data_in <= req_data;
            end
            // select held low only over the access: saves standby power
            pins_ff.select_n <= !(nxt_state == ST_READ ||
                nxt_state == ST_WSET || nxt_state == ST_WPULSE ||
                nxt_state == ST_WHOLD);
            // write strobe ends before select rises; data held after
            pins_ff.write_n <= (nxt_state != ST_WPULSE);
        end
    end

    // ---------------------------------------------------------------
    // user side
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 1'b0;
        end else begin
            ready_ff <= (nxt_state == ST_IDLE) &&
                !(state_ff == ST_IDLE && req_valid);
            rsp_valid_ff <= (state_ff == ST_READ) && cnt_done;
            if (state_ff == ST_READ && cnt_done) begin
                rsp_data_ff <= dout_s2_ff;
            end
        end
    end

    assign req_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign mem_pins = pins_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_addr_stable_write;
        @(posedge mclk) disable iff (!nrst)
        !pins_ff.write_n |-> $stable(pins_ff.word_address);
    endproperty
    a_addr_stable_write: assert property (p_addr_stable_write)
        else $error("address moved under write strobe");

    property p_write_inside_select;
        @(posedge mclk) disable iff (!nrst)
        !pins_ff.write_n |-> !pins_ff.select_n;
    endproperty
    a_write_inside_select: assert property (p_write_inside_select)
        else $error("write strobe outside select");

    property p_data_hold;
        @(posedge mclk) disable iff (!nrst)
        $rose(pins_ff.write_n) |-> $stable(pins_ff.data_in) &&
            !pins_ff.select_n;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("input data not held after write strobe");

    property p_setup;
        @(posedge mclk) disable iff (!nrst)
        $fell(pins_ff.write_n) |-> !$past(pins_ff.select_n);
    endproperty
    a_setup: assert property (p_setup)
        else $error("no address setup before write strobe");

    property p_pulse_width;
        @(posedge mclk) disable iff (!nrst)
        $fell(pins_ff.write_n) |-> !pins_ff.write_n [*4];
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("write pulse too short");

    property p_read_len;
        @(posedge mclk) disable iff (!nrst)
        (state_ff == ST_IDLE && req_valid && !req_write) |->
            ##11 rsp_valid_ff;
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read answer not at access time plus sync");

    property p_read_select;
        @(posedge mclk) disable iff (!nrst)
        $rose(rsp_valid_ff) |-> !$past(pins_ff.select_n) &&
            $past(pins_ff.write_n);
    endproperty
    a_read_select: assert property (p_read_select)
        else $error("read sampled while not selected");

    property p_wake;
        @(posedge mclk) disable iff (!nrst)
        (state_ff == ST_WAKE) |-> pins_ff.select_n && !ready_ff;
    endproperty
    a_wake: assert property (p_wake)
        else $error("access during start-up wait");

    property p_idle_deselect;
        @(posedge mclk) disable iff (!nrst)
        ready_ff |-> pins_ff.select_n && pins_ff.write_n;
    endproperty
    a_idle_deselect: assert property (p_idle_deselect)
        else $error("memory selected while idle");

    property p_addr_after_write;
        @(posedge mclk) disable iff (!nrst)
        $rose(pins_ff.write_n) |-> $stable(pins_ff.word_address);
    endproperty
    a_addr_after_write: assert property (p_addr_after_write)
        else $error("address moved as write strobe ended");

    // a take right after ready may move data_in, but only an edge later
    property p_data_after_select;
        @(posedge mclk) disable iff (!nrst)
        $rose(pins_ff.select_n) |-> $stable(pins_ff.data_in);
    endproperty
    a_data_after_select: assert property (p_data_after_select)
        else $error("input data moved as select rose");
endmodule // asr_host

/* tb/asr_mem_model.sv */
// behavioural one-bit static memory seen by the host's pins.
// assumes pins from asr_host; times in ns, no clock of its own.
`timescale 1ns/1ps
module asr_mem_model (
    input wire asr_pkg::asr_pins_t pins,
    output logic data_out
);
    import asr_pkg::*;
    logic mem [WORDS];
    logic in_wr = 1'b0;
    logic [ADDR_W-1:0] w_addr;
    logic w_data;
    realtime t_ok = 0.0;
    // ----
    // access and write
    // ----
    always @(negedge pins.select_n or pins.word_address) begin
        t_ok = $realtime + ACCESS_NS;
    end
    // bit taken from values held just before the first strobe rise
    always @(pins) begin
        if (in_wr && (pins.select_n || pins.write_n)) begin
            mem[w_addr] = w_data;
        end
        in_wr = !pins.select_n && !pins.write_n;
        w_addr = pins.word_address;
        w_data = pins.data_in;
    end
    // released output toggles, so a held bit never passes for data
    initial begin
        data_out = 1'b0;
        #0.5;
        forever begin
            if (pins.select_n !== 1'b0 || pins.write_n !== 1'b1) begin
                data_out = ~data_out;
            end else if ($realtime < t_ok) begin
                data_out = ~mem[pins.word_address];
            end else begin
                data_out = mem[pins.word_address];
            end
            #1;
        end
    end
endmodule // asr_mem_model

/* tb/async_sram_16k_by_1_test.sv */
// bench for asr_host driving the behavioural memory model.
// assumes a short start-up count to keep the run brief.
`timescale 1ns/1ps
module async_sram_16k_by_1_test;
    import asr_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = 14'h0000;
    logic req_data = 1'b0;
    logic req_ready;
    logic rsp_valid;
    logic rsp_data;
    logic mem_data_out;
    asr_pins_t mem_pins;
    asr_pins_t prev;
    logic seen_ready = 1'b0;
    logic w_same;
    int n_fail = 0;
    int n_compared = 0;
    always #5 mclk = ~mclk;
    asr_host #(.STARTUP_CYCLES(10)) DUT (
        .mclk(mclk),
        .nrst(nrst),
        .req_valid(req_valid),
        .req_write(req_write),
        .req_addr(req_addr),
        .req_data(req_data),
        .req_ready(req_ready),
        .rsp_valid(rsp_valid),
        .rsp_data(rsp_data),
        .mem_pins(mem_pins),
        .mem_data_out(mem_data_out)
    );
    asr_mem_model MEM (.pins(mem_pins), .data_out(mem_data_out));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_bit(string what, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_cnt(string what, int exp, int got);
        n_compared++;
        if (got != exp) begin
            n_fail++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic timeout();
        n_fail++;
        $display("[ERR] wait expected done seen timeout");
        final_report();
    endtask
    task automatic wait_ready();
        for (int i = 0; req_ready !== 1'b1; i++) begin
            if (i == 300) timeout();
            @(posedge mclk);
            #1;
        end
    endtask
    // n counts edges from the take edge to the finish
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic d, output int n);
        wait_ready();
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_data <= d;
        @(posedge mclk);
        req_valid <= 1'b0;
        for (n = 1; n < 300; n++) begin
            @(posedge mclk);
            #1;
            if (w ? req_ready === 1'b1 : rsp_valid === 1'b1) break;
        end
        if (n >= 300) timeout();
        chk_bit("addr pins", 1'b1, mem_pins.word_address === a);
    endtask
    // ----
    // wire watch
    // ----
    always @(posedge mclk) begin
        w_same = mem_pins.word_address === prev.word_address
            && mem_pins.data_in === prev.data_in;
        if (nrst !== 1'b1) begin
            seen_ready = 1'b0;
        end else begin
            if (mem_pins.write_n === 1'b0) begin
                chk_bit("wr held", 1'b1, w_same);
                chk_bit("wr select", 1'b0, prev.select_n);
            end
            if (!seen_ready) chk_bit("wake sel", 1'b1, mem_pins.select_n);
            seen_ready = seen_ready | (req_ready === 1'b1);
        end
        prev = mem_pins;
    end
    // ----
    // scenarios
    // ----
    task automatic t_start();
        repeat (20) @(posedge mclk);
        #1;
        chk_bit("rst select", 1'b1, mem_pins.select_n);
        chk_bit("rst write", 1'b1, mem_pins.write_n);
        chk_bit("rst ready", 1'b0, req_ready);
        @(posedge mclk);
        nrst <= 1'b1;
        wait_ready();
    endtask
    task automatic t_rw();
        logic [ADDR_W-1:0] a [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
        int n;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, a[i], i[0], n);
            chk_cnt("wr cycles", SETUP_CYC + PULSE_CYC + HOLD_CYC, n);
        end
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, a[i], 1'b0, n);
            chk_cnt("rd cycles", ACCESS_CYC + 3, n);
            chk_bit("rd data", i[0], rsp_data);
        end
    endtask
    task automatic t_b2b();
        int n;
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 14'h0ABC, ~i[0], n);
            xfer(1'b0, 14'h0ABC, 1'b0, n);
            chk_bit("rd after wr", ~i[0], rsp_data);
        end
    endtask
    initial begin
        t_start();
        t_rw();
        t_b2b();
        final_report();
    end
endmodule // async_sram_16k_by_1_test
